/* dv/cfq_host_model.sv */
// Host model of the flash bus: command writes and word reads, one at a time.
// Assumes the bench resolves the data wire from the device output enable.
`timescale 1ns/100ps
module cfq_host_model
    import cfq_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              dq_oe_n_i,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic                   ce_n_o,
    output logic                   oe_n_o,
    output logic                   we_n_o,
    output logic      [ADDR_W-1:0] addr_o,
    output logic      [DATA_W-1:0] dq_o
);
    initial begin
        {ce_n_o, oe_n_o, we_n_o} = 3'b111;
        addr_o = '0;
        dq_o   = 16'h5a5a;
    end
    function automatic logic [31:0] block_base(input logic [31:0] idx);
        block_base = idx * 32'h8000;
    endfunction
    task automatic write_cmd(input logic [BYTE_W-1:0] cmd);
        @(posedge clk_sys_i);
        {ce_n_o, we_n_o} <= 2'b00;
        dq_o <= {8'h00, cmd};
        repeat (3) @(posedge clk_sys_i);
        we_n_o <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        ce_n_o <= 1'b1;
        dq_o   <= ~dq_o;
        repeat (4) @(posedge clk_sys_i);
    endtask
    task automatic read_word(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic to);
        @(posedge clk_sys_i);
        {ce_n_o, oe_n_o} <= 2'b00;
        addr_o <= a;
        to = 1'b1;
        for (int i = 0; i < 12 && to; i++) begin
            @(posedge clk_sys_i);
            to = dq_oe_n_i !== 1'b0;
        end
        repeat (2) @(posedge clk_sys_i);
        d = dq_i;
        {ce_n_o, oe_n_o} <= 2'b11;
        repeat (4) @(posedge clk_sys_i);
    endtask
endmodule

/* dv/cfq_query_table_asserts.sv */
// Checker for the query database block: table bytes, byte lanes, drive enable, mode changes.
// Assumes it is bound to the top module; table reads are judged once the pins have settled.
`timescale 1ns/100ps
module cfq_query_table_asserts
    import cfq_pkg::*;
#(
    // Arbitrary neutral value for the primary command-set code
    parameter logic [15:0] PRI_CMD_SET  = 16'h00a5,
    parameter logic [7:0]  DEV_SIZE_EXP = 8'h17
)
(
    input wire logic              clk_sys_i,
    input wire logic              nrst_i,
    input wire logic              bus_ce_n_i,
    input wire logic              bus_oe_n_i,
    input wire logic              bus_we_n_i,
    input wire logic [ADDR_W-1:0] bus_addr_i,
    input wire logic [DATA_W-1:0] dq_o,
    input wire logic              dq_oe_n_o,
    input wire logic              query_mode_o
);
    localparam logic [7:0] TAB [26] = '{8'h51, 8'h52, 8'h59, PRI_CMD_SET[7:0], PRI_CMD_SET[15:8], 8'h0a,
        8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h17, 8'h20, 8'h85, 8'h95, 8'h08, 8'h09, 8'h0a, 8'h00, 8'h01,
        8'h01, 8'h02, 8'h00, DEV_SIZE_EXP, 8'h01, 8'h00};
    logic [10:0] p1_r, p2_r, p3_r, p4_r;
    logic [2:0]  q_r;
    logic [3:0]  wcnt_r;
    logic        st, ok;
    wire  [10:0] pins = {bus_ce_n_i, bus_oe_n_i, bus_we_n_i, bus_addr_i};
    // Pin history, mode history and cycles since the write strobe was low
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            {p1_r, p2_r, p3_r, p4_r} <= '1;
            q_r    <= '0;
            wcnt_r <= 4'hf;
        end else begin
            {p1_r, p2_r, p3_r, p4_r} <= {pins, p1_r, p2_r, p3_r};
            q_r    <= {q_r[1:0], query_mode_o};
            wcnt_r <= !bus_we_n_i ? 4'h0 : wcnt_r + {3'h0, wcnt_r != 4'hf};
        end
    end
    assign st = pins == p1_r && p1_r == p2_r && p2_r == p3_r && p3_r == p4_r;
    assign ok = st && pins[10:8] == 3'b001 && query_mode_o && &q_r;
    function automatic logic [15:0] tv(input logic [7:0] a);
        tv = (a >= 8'h10 && a <= 8'h29) ? {8'h00, TAB[a - 8'h10]} : 16'h0000;
    endfunction
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    property tab_prop(lo, hi);
        ok && bus_addr_i >= lo && bus_addr_i <= hi |-> dq_o == tv(bus_addr_i);
    endproperty
    sequence s_write_done;
        wcnt_r <= 4'h6;
    endsequence
    a_sig_bytes:    assert property (tab_prop(8'h10, 8'h12)) else $error("signature byte");
    a_pri_code:     assert property (tab_prop(8'h13, 8'h14)) else $error("primary code");
    a_ext_pointer:  assert property (tab_prop(8'h15, 8'h16)) else $error("table pointer");
    a_no_second:    assert property (tab_prop(8'h17, 8'h1a)) else $error("zero fields");
    a_supply_volts: assert property (tab_prop(8'h1b, 8'h1e)) else $error("supply byte");
    a_typ_times:    assert property (tab_prop(8'h1f, 8'h22)) else $error("typical time");
    a_max_times:    assert property (tab_prop(8'h23, 8'h26)) else $error("max time");
    a_iface_code:   assert property (tab_prop(8'h28, 8'h29)) else $error("interface code");
    a_upper_zero:   assert property (query_mode_o && $past(query_mode_o) |-> dq_o[15:8] == 8'h00)
        else $error("upper byte");
    a_drive_read:   assert property (st |-> dq_oe_n_o == (bus_ce_n_i | bus_oe_n_i | !bus_we_n_i))
        else $error("output enable");
    a_mode_by_write: assert property (query_mode_o != $past(query_mode_o) |-> s_write_done)
        else $error("mode change");
endmodule

/* dv/cfq_query_table_tb.sv */
// Bench for the query database block: array reads, table sweep, random reads, commands.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module cfq_query_table_tb
    import cfq_pkg::*;
;
    localparam logic [15:0] PRI = 16'h00a5; // Arbitrary value
    localparam logic [7:0]  DSZ = 8'h18;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    logic              ce_n, oe_n, we_n, dq_oe_n, qmode, to;
    logic [ADDR_W-1:0] arr_addr, a;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] host_dq, dq_out, rd;
    logic [DATA_W-1:0] arr_data = 16'h0000;
    logic [BYTE_W-1:0] cmd;
    int                fail_count = 0;
    int                total_checks = 0;
    int                seed = 80857;
    wire  [DATA_W-1:0] dq_wire = dq_oe_n ? host_dq : dq_out;
    always #50 clk = ~clk;
    cfq_query_table #(.PRI_CMD_SET(PRI), .DEV_SIZE_EXP(DSZ)) cfq_query_table_inst (
        .clk_sys_i(clk), .nrst_i(nrst), .bus_ce_n_i(ce_n), .bus_oe_n_i(oe_n), .bus_we_n_i(we_n),
        .bus_addr_i(addr), .dq_i(dq_wire), .dq_o(dq_out), .dq_oe_n_o(dq_oe_n), .array_rdata_i(arr_data),
        .array_addr_o(arr_addr), .query_mode_o(qmode));
    cfq_host_model cfq_host_model_inst (
        .clk_sys_i(clk), .dq_oe_n_i(dq_oe_n), .dq_i(dq_wire), .ce_n_o(ce_n), .oe_n_o(oe_n),
        .we_n_o(we_n), .addr_o(addr), .dq_o(host_dq));
    function automatic logic [15:0] exp_q(input logic [7:0] x);
        logic [7:0] t [26];
        t = '{8'h51, 8'h52, 8'h59, PRI[7:0], PRI[15:8], 8'h0a, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h17,
              8'h20, 8'h85, 8'h95, 8'h08, 8'h09, 8'h0a, 8'h00, 8'h01, 8'h01, 8'h02, 8'h00, DSZ, 8'h01, 8'h00};
        exp_q = (x >= 8'h10 && x <= 8'h29) ? {8'h00, t[x - 8'h10]} : 16'h0000;
    endfunction
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] x, input logic [15:0] e);
        cfq_host_model_inst.read_word(x, rd, to);
        if (to) begin
            fail_count++;
            $display("ERROR %0t read timeout", $time);
            conclude();
        end else begin
            `CHK(rd, e)
        end
    endtask
    task automatic sweep(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            rd_chk(8'(i), exp_q(8'(i)));
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        arr_data <= 16'($random(seed));
        @(posedge clk);
        rd_chk(8'h10, arr_data);
        `CHK(cfq_host_model_inst.block_base(32'h1), 32'h0000_8000)
        `CHK(arr_addr, 8'h10)
        `CHK(qmode, 1'b0)
        cfq_host_model_inst.write_cmd(CMD_QUERY);
        `CHK(qmode, 1'b1)
        sweep(8'h10, 8'h1a);
        sweep(8'h1b, 8'h26);
        sweep(8'h27, 8'h2f);
        sweep(8'h00, 8'h0f);
        for (int i = 0; i < 16; i++) begin
            a = 8'($unsigned($random(seed)) % 48);
            rd_chk(a, exp_q(a));
            rd_chk(a, exp_q(a));
        end
        for (int i = 0; i < 4; i++) begin
            cmd = 8'($random(seed));
            cmd = (cmd == CMD_QUERY || cmd == CMD_READ_ARRAY) ? 8'h00 : cmd;
            cfq_host_model_inst.write_cmd(cmd);
            `CHK(qmode, 1'b1)
        end
        cfq_host_model_inst.write_cmd(CMD_READ_ARRAY);
        `CHK(qmode, 1'b0)
        rd_chk(8'h2a, arr_data);
        cfq_host_model_inst.write_cmd(CMD_READ_ARRAY);
        `CHK(qmode, 1'b0)
        cfq_host_model_inst.write_cmd(CMD_QUERY);
        `CHK(qmode, 1'b1)
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        `CHK(qmode, 1'b0)
        rd_chk(8'h12, arr_data);
        conclude();
    end
endmodule
bind cfq_query_table cfq_query_table_asserts #(.PRI_CMD_SET(PRI_CMD_SET), .DEV_SIZE_EXP(DEV_SIZE_EXP)) chk_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus_ce_n_i(bus_ce_n_i), .bus_oe_n_i(bus_oe_n_i),
    .bus_we_n_i(bus_we_n_i), .bus_addr_i(bus_addr_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
    .query_mode_o(query_mode_o));

/* hw/cfq_bus_strobe.sv */
// Decodes read and write bus cycles from the synchronised flash pins.
// Assumes inputs are already in the system clock domain.
`timescale 1ns/100ps
module cfq_bus_strobe
    import cfq_pkg::*;
(
    input  wire logic     clk_sys_i,
    input  wire logic     nrst_i,
    input  wire cfq_bus_t bus_i,
    output logic          read_active_o,
    output logic          write_pulse_o,
    output logic [DATA_W-1:0] write_data_o
);

    logic              we_n_prev_r;
    logic              ce_n_prev_r;
    logic [DATA_W-1:0] data_prev_r;

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            we_n_prev_r <= 1'b1;
            ce_n_prev_r <= 1'b1;
            data_prev_r <= '0;
        end else begin
            we_n_prev_r <= bus_i.we_n;
            ce_n_prev_r <= bus_i.ce_n;
            data_prev_r <= bus_i.data;
        end
    end

    // Command is latched on the rising edge of the write strobe
    assign write_pulse_o = !we_n_prev_r && bus_i.we_n && !ce_n_prev_r;
    assign write_data_o  = data_prev_r;
    assign read_active_o = !bus_i.ce_n && !bus_i.oe_n && bus_i.we_n;

endmodule

/* hw/cfq_pin_sync.sv */
// Two flip-flop synchroniser for the asynchronous flash bus pins.
// Assumes the pins are stable for several system clocks around each strobe edge.
`timescale 1ns/100ps
module cfq_pin_sync
    import cfq_pkg::*;
(
    input  wire logic     clk_sys_i,
    input  wire logic     nrst_i,
    input  wire cfq_bus_t bus_i,
    output cfq_bus_t      bus_o
);

    logic [BUS_W-1:0] meta_r;
    logic [BUS_W-1:0] sync_r;
    logic [BUS_W-1:0] bus_vec;

    assign bus_vec = bus_i;

    genvar gi;
    generate
        for (gi = 0; gi < BUS_W; gi++) begin : g_bit
            always_ff @(posedge clk_sys_i) begin
                if (!nrst_i) begin
                    meta_r[gi] <= BUS_IDLE[gi];
                    sync_r[gi] <= BUS_IDLE[gi];
                end else begin
                    meta_r[gi] <= bus_vec[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    assign bus_o = sync_r;

endmodule

/* hw/cfq_pkg.sv */
// Constants, types and the query table contents for the query database block.
// Assumes a 16-bit flash bus, word addressed, sampled on the 10 MHz system clock.
//
// Summary of operation
// - Offsets 10h-12h return 51h, 52h, 59h.
// - Offsets 13h/14h hold 16-bit primary command-set code.
// - Offsets 15h/16h hold extended table pointer 010Ah.
// - Alternate command-set code at 17h reads zero.
// - Secondary table address at 19h reads zero.
// - Core supply min/max at 1Bh/1Ch: 17h, 20h.
// - Programming supply min/max at 1Dh/1Eh: 85h, 95h.
// - Typical word program exponent at 1Fh is 08h.
// - Typical buffer write exponent at 20h is 09h.
// - Typical block erase exponent at 21h is 0Ah.
// - Chip erase entries at 22h, 26h read zero.
// - Max program/buffer multipliers at 23h/24h are 01h.
// - Max block erase multiplier at 25h is 02h.
// - Interface code at 28h is 0001h, x16 only.
// - Upper data byte is zero on every query read.
// - Multi-byte fields: least significant byte at lower offset.
// - Query data returned only after the query command.
package cfq_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned BYTE_W = 8;

    // Command codes written on the low data byte
    localparam logic [BYTE_W-1:0] CMD_QUERY      = 8'h98;
    localparam logic [BYTE_W-1:0] CMD_READ_ARRAY = 8'hff;

    // Query offsets (word addresses)
    localparam logic [ADDR_W-1:0] OFF_SIG_0      = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SIG_1      = 8'h11;
    localparam logic [ADDR_W-1:0] OFF_SIG_2      = 8'h12;
    localparam logic [ADDR_W-1:0] OFF_PRI_CMD_LO = 8'h13;
    localparam logic [ADDR_W-1:0] OFF_PRI_CMD_HI = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_PRI_EXT_LO = 8'h15;
    localparam logic [ADDR_W-1:0] OFF_PRI_EXT_HI = 8'h16;
    localparam logic [ADDR_W-1:0] OFF_ALT_CMD_LO = 8'h17;
    localparam logic [ADDR_W-1:0] OFF_ALT_CMD_HI = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_SEC_EXT_LO = 8'h19;
    localparam logic [ADDR_W-1:0] OFF_SEC_EXT_HI = 8'h1a;
    localparam logic [ADDR_W-1:0] OFF_VCORE_MIN  = 8'h1b;
    localparam logic [ADDR_W-1:0] OFF_VCORE_MAX  = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_VPROG_MIN  = 8'h1d;
    localparam logic [ADDR_W-1:0] OFF_VPROG_MAX  = 8'h1e;
    localparam logic [ADDR_W-1:0] OFF_TYP_WORD   = 8'h1f;
    localparam logic [ADDR_W-1:0] OFF_TYP_BUF    = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_TYP_BLOCK  = 8'h21;
    localparam logic [ADDR_W-1:0] OFF_TYP_CHIP   = 8'h22;
    localparam logic [ADDR_W-1:0] OFF_MAX_WORD   = 8'h23;
    localparam logic [ADDR_W-1:0] OFF_MAX_BUF    = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_MAX_BLOCK  = 8'h25;
    localparam logic [ADDR_W-1:0] OFF_MAX_CHIP   = 8'h26;
    localparam logic [ADDR_W-1:0] OFF_DEV_SIZE   = 8'h27;
    localparam logic [ADDR_W-1:0] OFF_IFACE_LO   = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_IFACE_HI   = 8'h29;

    // Table values
    localparam logic [23:0] VAL_SIGNATURE  = 24'h595251;
    localparam logic [15:0] VAL_PRI_EXT    = 16'h010a;
    localparam logic [15:0] VAL_ALT_CMD    = 16'h0000;
    localparam logic [15:0] VAL_SEC_EXT    = 16'h0000;
    localparam logic [7:0]  VAL_VCORE_MIN  = 8'h17;
    localparam logic [7:0]  VAL_VCORE_MAX  = 8'h20;
    localparam logic [7:0]  VAL_VPROG_MIN  = 8'h85;
    localparam logic [7:0]  VAL_VPROG_MAX  = 8'h95;
    localparam logic [7:0]  VAL_TYP_WORD   = 8'h08;
    localparam logic [7:0]  VAL_TYP_BUF    = 8'h09;
    localparam logic [7:0]  VAL_TYP_BLOCK  = 8'h0a;
    localparam logic [7:0]  VAL_TYP_CHIP   = 8'h00;
    localparam logic [7:0]  VAL_MAX_WORD   = 8'h01;
    localparam logic [7:0]  VAL_MAX_BUF    = 8'h01;
    localparam logic [7:0]  VAL_MAX_BLOCK  = 8'h02;
    localparam logic [7:0]  VAL_MAX_CHIP   = 8'h00;
    localparam logic [15:0] VAL_IFACE      = 16'h0001;
    localparam logic [7:0]  VAL_UNMAPPED   = 8'h00;
    localparam logic [7:0]  VAL_UPPER_BYTE = 8'h00;

    // Bus pins seen from the device
    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cfq_bus_t;

    localparam int unsigned BUS_W = $bits(cfq_bus_t);
    localparam cfq_bus_t BUS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};

    typedef enum logic [1:0] {
        CFQ_ST_ARRAY = 2'b01,
        CFQ_ST_QUERY = 2'b10
    } cfq_state_t;

endpackage

/* hw/cfq_query_table.sv */
// Flash bus front end with the query database and the command decoder.
// Assumes the flash pins are asynchronous to clk_sys_i and that array data
// for array_addr_o arrives on array_rdata_i from same-clock logic.
`timescale 1ns/100ps
module cfq_query_table
    import cfq_pkg::*;
#(
    // Arbitrary neutral value for the primary command-set code
    parameter logic [15:0] PRI_CMD_SET  = 16'h00a5,
    // Device size exponent, set per density
    parameter logic [7:0]  DEV_SIZE_EXP = 8'h17
)
(
    input  wire logic              clk_sys_i,
    input  wire logic              nrst_i,
    input  wire logic              bus_ce_n_i,
    input  wire logic              bus_oe_n_i,
    input  wire logic              bus_we_n_i,
    input  wire logic [ADDR_W-1:0] bus_addr_i,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic      [DATA_W-1:0] dq_o,
    output logic                   dq_oe_n_o,
    input  wire logic [DATA_W-1:0] array_rdata_i,
    output logic      [ADDR_W-1:0] array_addr_o,
    output logic                   query_mode_o
);

    cfq_bus_t          bus_raw;
    cfq_bus_t          bus_sync;
    logic              read_active;
    logic              write_pulse;
    logic [DATA_W-1:0] write_data;
    logic [BYTE_W-1:0] query_byte;

    cfq_state_t        state_r;
    cfq_state_t        state_nxt;
    logic [DATA_W-1:0] dq_r;
    logic              dq_oe_n_r;
    logic [ADDR_W-1:0] array_addr_r;
    logic              query_mode_r;

    assign bus_raw.ce_n = bus_ce_n_i;
    assign bus_raw.oe_n = bus_oe_n_i;
    assign bus_raw.we_n = bus_we_n_i;
    assign bus_raw.addr = bus_addr_i;
    assign bus_raw.data = dq_i;

    cfq_pin_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .bus_i     (bus_raw),
        .bus_o     (bus_sync)
    );

    cfq_bus_strobe u_strobe (
        .clk_sys_i     (clk_sys_i),
        .nrst_i        (nrst_i),
        .bus_i         (bus_sync),
        .read_active_o (read_active),
        .write_pulse_o (write_pulse),
        .write_data_o  (write_data)
    );

    // Pure lookup: reading never changes any state
    function automatic logic [BYTE_W-1:0] lookup(input logic [ADDR_W-1:0] off);
        logic [BYTE_W-1:0] b;
        b = VAL_UNMAPPED;
        case (off)
            OFF_SIG_0:      b = VAL_SIGNATURE[7:0];
            OFF_SIG_1:      b = VAL_SIGNATURE[15:8];
            OFF_SIG_2:      b = VAL_SIGNATURE[23:16];
            OFF_PRI_CMD_LO: b = PRI_CMD_SET[7:0];
            OFF_PRI_CMD_HI: b = PRI_CMD_SET[15:8];
            OFF_PRI_EXT_LO: b = VAL_PRI_EXT[7:0];
            OFF_PRI_EXT_HI: b = VAL_PRI_EXT[15:8];
            OFF_ALT_CMD_LO: b = VAL_ALT_CMD[7:0];
            OFF_ALT_CMD_HI: b = VAL_ALT_CMD[15:8];
            OFF_SEC_EXT_LO: b = VAL_SEC_EXT[7:0];
            OFF_SEC_EXT_HI: b = VAL_SEC_EXT[15:8];
            OFF_VCORE_MIN:  b = VAL_VCORE_MIN;
            OFF_VCORE_MAX:  b = VAL_VCORE_MAX;
            OFF_VPROG_MIN:  b = VAL_VPROG_MIN;
            OFF_VPROG_MAX:  b = VAL_VPROG_MAX;
            OFF_TYP_WORD:   b = VAL_TYP_WORD;
            OFF_TYP_BUF:    b = VAL_TYP_BUF;
            OFF_TYP_BLOCK:  b = VAL_TYP_BLOCK;
            OFF_TYP_CHIP:   b = VAL_TYP_CHIP;
            OFF_MAX_WORD:   b = VAL_MAX_WORD;
            OFF_MAX_BUF:    b = VAL_MAX_BUF;
            OFF_MAX_BLOCK:  b = VAL_MAX_BLOCK;
            OFF_MAX_CHIP:   b = VAL_MAX_CHIP;
            OFF_DEV_SIZE:   b = DEV_SIZE_EXP;
            OFF_IFACE_LO:   b = VAL_IFACE[7:0];
            OFF_IFACE_HI:   b = VAL_IFACE[15:8];
            default:        b = VAL_UNMAPPED;
        endcase
        return b;
    endfunction

    assign query_byte = lookup(bus_sync.addr);

    // Command decoder: only writes move the mode, reads never do
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CFQ_ST_ARRAY: begin
                if (write_pulse && write_data[BYTE_W-1:0] == CMD_QUERY) begin
                    state_nxt = CFQ_ST_QUERY;
                end
            end
            CFQ_ST_QUERY: begin
                if (write_pulse && write_data[BYTE_W-1:0] == CMD_READ_ARRAY) begin
                    state_nxt = CFQ_ST_ARRAY;
                end
            end
            default: state_nxt = CFQ_ST_ARRAY;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state_r      <= CFQ_ST_ARRAY;
            query_mode_r <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            query_mode_r <= (state_nxt == CFQ_ST_QUERY);
        end
    end

    // Read data path
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            dq_r <= '0;
        end else if (state_r == CFQ_ST_QUERY) begin
            dq_r <= {VAL_UPPER_BYTE, query_byte};
        end else begin
            dq_r <= array_rdata_i;
        end
    end

    // Drive the bus only during a read cycle; enable is active low
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            dq_oe_n_r <= 1'b1;
        end else begin
            dq_oe_n_r <= !read_active;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            array_addr_r <= '0;
        end else begin
            array_addr_r <= bus_sync.addr;
        end
    end

    assign dq_o         = dq_r;
    assign dq_oe_n_o    = dq_oe_n_r;
    assign array_addr_o = array_addr_r;
    assign query_mode_o = query_mode_r;

endmodule
